// >>> hw/pcr_cap_regs.sv
`timescale 1ns/1ps
`include "pcr_defines.svh"
// ****************************************
// Express capability register bank
// ****************************************
// Behaviour
// - Capability ID reads fixed 10h
// - Next pointer reads 00h, list ends
// - Capabilities bits 3:0 read version 2h
// - Capabilities bits 7:4 read bridge 0111b
// - Interrupt number and reserved bits read zero
// - Slot implemented bit reads zero
// - Device caps reserved bits read zero
// - Message payload 9:8 sets scale field
// - Message payload 7:0 sets value field
// - Role based error bit reads one
// - Lamp and button present bits read zero
// - Deep idle field follows control bits 15:13
// - Deep idle field resets to 110b
// - Light idle field follows control bits 18:16
// - Light idle field resets to 110b
// - Written tolerances never below physical exit latency; the 110b reset value is not raised to the floors
// - Ghost function and wide tag read zero
// - Largest payload field reads 010b
module pcr_cap_regs #(
  parameter logic [2:0] DEEP_FLOOR = 3'h0,
  parameter logic [2:0] LIGHT_FLOOR = 3'h0
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic cfg_rd,
  input wire logic cfg_wr,
  input wire logic [7:0] cfg_addr,
  input wire logic [31:0] cfg_wdata,
  input wire logic msg_valid,
  input wire logic [9:0] msg_payload,
  input wire logic gcr_wr,
  input wire logic [31:0] gcr_wdata,
  output logic cfg_rd_valid_q,
  output logic cfg_rd_hit_q,
  output logic [31:0] cfg_rd_data_q,
  output logic [17:0] slot_power_limit_mw_q
);
  // ****************************************
  // Internal signals
  // ****************************************
  pcr_pkg::pcr_top_state_type st_q; // Registered state
  pcr_pkg::pcr_top_state_type st_d; // Next state
  logic [1:0] captured_power_scale; // From the capture block
  logic [7:0] captured_power_value; // From the capture block
  logic [2:0] deep_idle_exit_tolerance; // From the mirror block
  logic [2:0] light_idle_exit_tolerance; // From the mirror block
  logic [15:0] exp_caps_word; // Assembled capabilities word
  logic [31:0] dev_caps_word; // Assembled device capabilities word
  logic [31:0] head_dword; // Dword holding ID, pointer, capabilities
  logic [31:0] rd_word; // Decoded read data
  logic rd_hit; // Read lands on a mapped dword

  // ****************************************
  // Hardware update sources
  // ****************************************
  // Message capture of the slot power limit
  pcr_power_capture u_power (
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce),
    .msg_valid(msg_valid),
    .msg_payload(msg_payload),
    .captured_power_scale(captured_power_scale),
    .captured_power_value(captured_power_value)
  );

  // Mirror of the general control latency fields
  pcr_latency_mirror #(
    .DEEP_FLOOR(DEEP_FLOOR),
    .LIGHT_FLOOR(LIGHT_FLOOR)
  ) u_latency (
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce),
    .gcr_wr(gcr_wr),
    .gcr_wdata(gcr_wdata),
    .deep_idle_exit_tolerance(deep_idle_exit_tolerance),
    .light_idle_exit_tolerance(light_idle_exit_tolerance)
  );

  // ****************************************
  // Word assembly
  // ****************************************
  // Capabilities word: all fields hardwired
  always_comb begin
    exp_caps_word = 16'h0000;
    exp_caps_word[3:0] = `PCR_VERSION_VAL;
    exp_caps_word[7:4] = `PCR_PORT_KIND_VAL;
    exp_caps_word[8] = `PCR_SLOT_IMPL_VAL;
    exp_caps_word[13:9] = `PCR_INT_NUM_VAL;
  end

  // Device capabilities word: live fields from the two sub-blocks
  always_comb begin
    dev_caps_word = 32'h00000000;
    dev_caps_word[2:0] = `PCR_MAX_PAYLOAD_VAL;
    dev_caps_word[4:3] = `PCR_GHOST_FN_VAL;
    dev_caps_word[5] = `PCR_WIDE_TAG_VAL;
    dev_caps_word[`PCR_DC_LIGHT_LSB +: 3] = light_idle_exit_tolerance;
    dev_caps_word[`PCR_DC_DEEP_LSB +: 3] = deep_idle_exit_tolerance;
    dev_caps_word[14:12] = `PCR_LAMPS_VAL;
    dev_caps_word[`PCR_DC_ROLE_BIT] = `PCR_ROLE_ERR_VAL;
    dev_caps_word[`PCR_DC_VALUE_LSB +: 8] = captured_power_value;
    dev_caps_word[`PCR_DC_SCALE_LSB +: 2] = captured_power_scale;
    // bits 31:28 and 17:16 stay zero from the default
  end

  assign head_dword = {exp_caps_word, `PCR_NEXT_PTR_VAL, `PCR_CAP_ID_VAL};

  // ****************************************
  // Read decode
  // ****************************************
  // Dword decode; the low two address bits select nothing since the
  // whole dword is returned and byte lanes are picked by the requester
  always_comb begin
    rd_word = 32'h00000000;
    rd_hit = 1'b0;
    if (cfg_addr[7:2] == 6'(`PCR_CAP_ID_OFS >> 2)) begin
      rd_word = head_dword;
      rd_hit = 1'b1;
    end else if (cfg_addr[7:2] == 6'(`PCR_DEV_CAPS_OFS >> 2)) begin
      rd_word = dev_caps_word;
      rd_hit = 1'b1;
    end
  end

  function automatic logic [17:0] limit_in_mw(input logic [1:0] scale, input logic [7:0] value);
    logic [9:0] mult;
    mult = 10'd1;
    unique case (scale)
      2'h0: mult = 10'd1000;
      2'h1: mult = 10'd100;
      2'h2: mult = 10'd10;
      2'h3: mult = 10'd1;
    endcase
    limit_in_mw = 18'(value) * 18'(mult);
  endfunction

  // ****************************************
  // State update
  // ****************************************
  // Next state: read answers one cycle later, writes have no path in
  always_comb begin
    st_d = st_q;
    st_d.rd_valid = cfg_rd;
    if (cfg_rd) begin
      // Unmapped addresses answer zero with hit low
      st_d.rd_data = rd_word;
      st_d.rd_hit = rd_hit;
    end
    st_d.limit_mw = limit_in_mw(captured_power_scale, captured_power_value);
    // cfg_wr and cfg_wdata drive nothing, so writes are dropped
  end

  // State register, frozen while ce is low
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= '{rd_valid: 1'b0, rd_hit: 1'b0, rd_data: 32'h00000000,
                limit_mw: 18'h00000};
    end else if (ce) begin
      st_q <= st_d;
    end
  end

  assign cfg_rd_valid_q = st_q.rd_valid;
  assign cfg_rd_hit_q = st_q.rd_hit;
  assign cfg_rd_data_q = st_q.rd_data;
  assign slot_power_limit_mw_q = st_q.limit_mw;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  // A read of the head dword with ce high
  sequence head_read;
    ce && cfg_rd && cfg_addr[7:2] == 6'h1C;
  endsequence

  // A read of the device capabilities dword with ce high
  sequence dev_read;
    ce && cfg_rd && cfg_addr[7:2] == 6'h1D;
  endsequence

  // A message followed by a quiet read of the device caps
  sequence msg_then_read;
    (ce && msg_valid) ##1 (dev_read and !msg_valid);
  endsequence

  // A control write followed by a quiet read of the device caps
  sequence gcr_then_read;
    (ce && gcr_wr) ##1 (dev_read and !gcr_wr);
  endsequence

  a_id_byte_fixed: assert property (
    head_read |=> cfg_rd_valid_q && cfg_rd_data_q[7:0] == 8'h10)
    else $error("capability id wrong");

  a_next_ptr_zero: assert property (
    head_read |=> cfg_rd_data_q[15:8] == 8'h00)
    else $error("next pointer not zero");

  a_caps_kind_version: assert property (
    head_read |=> cfg_rd_data_q[23:16] == 8'h72 && cfg_rd_hit_q)
    else $error("version or port kind wrong");

  a_caps_upper_zero: assert property (
    head_read |=> cfg_rd_data_q[31:24] == 8'h00)
    else $error("interrupt, slot or reserved bits set");

  a_dev_fixed_bits: assert property (
    dev_read |=> cfg_rd_data_q[31:28] == 4'h0 && cfg_rd_data_q[17:12] == 6'h08
      && cfg_rd_data_q[5:0] == 6'h02)
    else $error("device caps fixed bits wrong");

  a_power_capture: assert property (
    msg_then_read |=> cfg_rd_data_q[27:18] == $past(msg_payload, 2))
    else $error("power limit not captured");

  a_latency_mirror: assert property (
    (ce && gcr_wr) ##1 (dev_read and !gcr_wr) |=>
      cfg_rd_data_q[11:9] >= DEEP_FLOOR && cfg_rd_data_q[8:6] >= LIGHT_FLOOR
      && (cfg_rd_data_q[11:9] == $past(gcr_wdata[15:13], 2)
          || $past(gcr_wdata[15:13], 2) < DEEP_FLOOR))
    else $error("latency mirror wrong");

  a_unmapped_zero: assert property (
    ce && cfg_rd && cfg_addr[7:3] != 5'h0E |=> !cfg_rd_hit_q && cfg_rd_data_q == 32'h0)
    else $error("unmapped read not zero");

  a_limit_scale: assert property (
    ce && captured_power_scale == 2'h0 ##1 ce |->
      slot_power_limit_mw_q == 18'(captured_power_value) * 18'd1000
      || $changed(captured_power_value))
    else $error("power limit scaling wrong");

  a_read_once: assert property (
    ce && !cfg_rd |=> !cfg_rd_valid_q)
    else $error("answer without a read");

  a_caps_word_whole: assert property (
    head_read |=> cfg_rd_data_q[31:16] == `PCR_EXP_CAPS_RST)
    else $error("capabilities word wrong");

  a_slot_absent: assert property (
    head_read |=> !cfg_rd_data_q[24])
    else $error("slot implemented bit set");

  a_dev_reserved_zero: assert property (
    dev_read |=> cfg_rd_data_q[31:28] == 4'h0 && cfg_rd_data_q[17:16] == 2'h0)
    else $error("device caps reserved bits set");

  a_value_capture: assert property (
    msg_then_read |=> cfg_rd_data_q[25:18] == $past(msg_payload[7:0], 2))
    else $error("power value not captured");

  // finest scale passes the value through
  a_limit_fine: assert property (
    ce && captured_power_scale == 2'h3 ##1 ce |->
      slot_power_limit_mw_q == 18'(captured_power_value) || $changed(captured_power_value))
    else $error("power limit fine scale wrong");

  a_lamps_absent: assert property (
    dev_read |=> cfg_rd_data_q[14:12] == 3'h0)
    else $error("lamp or button bit set");

  a_deep_reset: assert property (
    $rose(rst_n) |-> deep_idle_exit_tolerance == `PCR_LAT_RST)
    else $error("deep idle reset value wrong");

  // light idle follows the write, raised to the floor
  a_light_mirror: assert property (
    gcr_then_read |=> cfg_rd_data_q[8:6] == (($past(gcr_wdata[18:16], 2) < LIGHT_FLOOR)
      ? LIGHT_FLOOR : $past(gcr_wdata[18:16], 2)))
    else $error("light idle mirror wrong");

  a_light_reset: assert property (
    $rose(rst_n) |-> light_idle_exit_tolerance == `PCR_LAT_RST)
    else $error("light idle reset value wrong");

  // deep idle raised to the floor
  a_deep_clamp: assert property (
    gcr_then_read |=> cfg_rd_data_q[11:9] == (($past(gcr_wdata[15:13], 2) < DEEP_FLOOR)
      ? DEEP_FLOOR : $past(gcr_wdata[15:13], 2)))
    else $error("deep idle floor wrong");

  // 512 byte payload, no ghost functions or wide tags
  a_payload_support: assert property (
    dev_read |=> cfg_rd_data_q[2:0] == 3'h2 && cfg_rd_data_q[5:3] == 3'h0)
    else $error("payload or tag fields wrong");

  // a config write alone changes no register
  a_write_ignored: assert property (
    ce && cfg_wr && !msg_valid && !gcr_wr |=> $stable(dev_caps_word) && $stable(head_dword))
    else $error("config write changed a register");
endmodule

// >>> hw/pcr_defines.svh
`ifndef PCR_DEFINES_SVH
`define PCR_DEFINES_SVH
// ****************************************
// Register offsets (byte addresses)
// ****************************************
`define PCR_CAP_ID_OFS 8'h70
`define PCR_NEXT_PTR_OFS 8'h71
`define PCR_EXP_CAPS_OFS 8'h72
`define PCR_DEV_CAPS_OFS 8'h74
// ****************************************
// Fixed field values
// ****************************************
`define PCR_CAP_ID_VAL 8'h10
`define PCR_NEXT_PTR_VAL 8'h00
`define PCR_VERSION_VAL 4'h2
`define PCR_PORT_KIND_VAL 4'h7
`define PCR_INT_NUM_VAL 5'h00
`define PCR_SLOT_IMPL_VAL 1'h0
`define PCR_ROLE_ERR_VAL 1'h1
`define PCR_LAMPS_VAL 3'h0
`define PCR_WIDE_TAG_VAL 1'h0
`define PCR_GHOST_FN_VAL 2'h0
`define PCR_MAX_PAYLOAD_VAL 3'h2
// ****************************************
// Reset values
// ****************************************
`define PCR_LAT_RST 3'h6
`define PCR_SCALE_RST 2'h0
`define PCR_VALUE_RST 8'h00
`define PCR_EXP_CAPS_RST 16'h0072
`define PCR_DEV_CAPS_RST 32'h00008D82
// ****************************************
// Field positions
// ****************************************
`define PCR_MSG_SCALE_LSB 8
`define PCR_MSG_VALUE_LSB 0
`define PCR_GCR_DEEP_LSB 13
`define PCR_GCR_LIGHT_LSB 16
`define PCR_DC_SCALE_LSB 26
`define PCR_DC_VALUE_LSB 18
`define PCR_DC_DEEP_LSB 9
`define PCR_DC_LIGHT_LSB 6
`define PCR_DC_ROLE_BIT 15
`endif

// >>> hw/pcr_latency_mirror.sv
`timescale 1ns/1ps
`include "pcr_defines.svh"
// Mirrors the exit latency tolerances written to the general control register
module pcr_latency_mirror #(
  parameter logic [2:0] DEEP_FLOOR = 3'h0,
  parameter logic [2:0] LIGHT_FLOOR = 3'h0
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic gcr_wr,
  input wire logic [31:0] gcr_wdata,
  output logic [2:0] deep_idle_exit_tolerance,
  output logic [2:0] light_idle_exit_tolerance
);
  pcr_pkg::pcr_latency_state_type st_q; // Registered state
  pcr_pkg::pcr_latency_state_type st_d; // Next state
  logic [2:0] deep_idle_tolerance_setting; // Written deep idle code
  logic [2:0] light_idle_tolerance_setting; // Written light idle code

  // Raise a code to the physical layer's own floor
  function automatic logic [2:0] floor_code(input logic [2:0] code, input logic [2:0] lim);
    floor_code = (code < lim) ? lim : code;
  endfunction

  assign deep_idle_tolerance_setting = gcr_wdata[`PCR_GCR_DEEP_LSB +: 3];
  assign light_idle_tolerance_setting = gcr_wdata[`PCR_GCR_LIGHT_LSB +: 3];

  // Next state: follow each write, never below the floor
  always_comb begin
    st_d = st_q;
    if (gcr_wr) begin
      st_d.deep = floor_code(deep_idle_tolerance_setting, DEEP_FLOOR);
      st_d.light = floor_code(light_idle_tolerance_setting, LIGHT_FLOOR);
    end
  end

  // State register, frozen while ce is low
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= '{deep: `PCR_LAT_RST, light: `PCR_LAT_RST};
    end else if (ce) begin
      st_q <= st_d;
    end
  end

  assign deep_idle_exit_tolerance = st_q.deep;
  assign light_idle_exit_tolerance = st_q.light;
endmodule

// >>> hw/pcr_pkg.sv
package pcr_pkg;
  // Power limit capture state
  typedef struct packed {
    logic [1:0] scale;
    logic [7:0] value;
  } pcr_power_state_type;

  // Latency tolerance mirror state
  typedef struct packed {
    logic [2:0] deep;
    logic [2:0] light;
  } pcr_latency_state_type;

  // Top-level read path state
  typedef struct packed {
    logic rd_valid;
    logic rd_hit;
    logic [31:0] rd_data;
    logic [17:0] limit_mw;
  } pcr_top_state_type;
endpackage

// >>> hw/pcr_power_capture.sv
`timescale 1ns/1ps
`include "pcr_defines.svh"
// Captures the slot power limit carried by a received message
module pcr_power_capture (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic msg_valid,
  input wire logic [9:0] msg_payload,
  output logic [1:0] captured_power_scale,
  output logic [7:0] captured_power_value
);
  pcr_pkg::pcr_power_state_type st_q; // Registered state
  pcr_pkg::pcr_power_state_type st_d; // Next state

  // Next state: overwrite both fields on every message
  always_comb begin
    st_d = st_q;
    if (msg_valid) begin
      st_d.scale = msg_payload[`PCR_MSG_SCALE_LSB +: 2];
      st_d.value = msg_payload[`PCR_MSG_VALUE_LSB +: 8];
    end
  end

  // State register, frozen while ce is low
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= '{scale: `PCR_SCALE_RST, value: `PCR_VALUE_RST};
    end else if (ce) begin
      st_q <= st_d;
    end
  end

  assign captured_power_scale = st_q.scale;
  assign captured_power_value = st_q.value;
endmodule

// >>> test/pcr_cap_regs_tb.sv
`timescale 1ns/1ps
// ****************************************
// Capability register bank bench
// ****************************************
module pcr_cap_regs_tb;
  // Nonzero floors so the clamp path is exercised
  localparam logic [2:0] DF = 3'h1;
  localparam logic [2:0] LF = 3'h2;
  logic clk, rst_n, ce, cfg_rd, cfg_wr, msg_valid, gcr_wr;
  logic [7:0] cfg_addr;
  logic [31:0] cfg_wdata, gcr_wdata, rd_data;
  logic [9:0] msg_payload;
  logic rd_valid, rd_hit;
  logic [17:0] limit_mw;
  int err_count, checks_done;
  // Expected field state
  logic [1:0] sc_m;
  logic [7:0] val_m;
  logic [2:0] dp_m, lt_m;

  // 20 MHz clock
  always #25 clk = ~clk;

  pcr_cap_regs #(.DEEP_FLOOR(DF), .LIGHT_FLOOR(LF)) dut_u (
    .clk(clk), .rst_n(rst_n), .ce(ce), .cfg_rd(cfg_rd), .cfg_wr(cfg_wr),
    .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata), .msg_valid(msg_valid),
    .msg_payload(msg_payload), .gcr_wr(gcr_wr), .gcr_wdata(gcr_wdata),
    .cfg_rd_valid_q(rd_valid), .cfg_rd_hit_q(rd_hit), .cfg_rd_data_q(rd_data),
    .slot_power_limit_mw_q(limit_mw)
  );

  pcr_root_model root_u (
    .clk(clk), .msg_valid(msg_valid), .msg_payload(msg_payload),
    .gcr_wr(gcr_wr), .gcr_wdata(gcr_wdata)
  );

  // Device capabilities word built from the expected fields
  function automatic logic [31:0] dev_caps();
    return {4'h0, sc_m, val_m, 2'h0, 1'h1, 3'h0, dp_m, lt_m, 1'h0, 2'h0, 3'h2};
  endfunction

  // Power limit in milliwatts for the expected scale code
  function automatic logic [17:0] exp_mw();
    int m;
    m = (sc_m == 2'h0) ? 1000 : (sc_m == 2'h1) ? 100 : (sc_m == 2'h2) ? 10 : 1;
    return 18'(int'(val_m) * m);
  endfunction

  task automatic chk_data(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %0t data %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_flag(input logic got, input logic exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %0t flag %b expected %b", $time, got, exp);
    end
  endtask

  task automatic chk_mw(input logic [17:0] got, input logic [17:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %0t limit %0d expected %0d", $time, got, exp);
    end
  endtask

  // Read request stays up so calls run back to back; answer due one edge later
  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic hit);
    cfg_rd = 1'h1;
    cfg_addr = a;
    @(negedge clk);
    chk_flag(rd_valid, 1'h1);
    chk_flag(rd_hit, hit);
    chk_data(rd_data, exp);
  endtask

  // Drop the request; the answer strobe must last one cycle only
  task automatic idle();
    cfg_rd = 1'h0;
    cfg_addr = ~cfg_addr;
    @(negedge clk);
    chk_flag(rd_valid, 1'h0);
  endtask

  task automatic report_and_stop();
    $display("errors %0d checks %0d", err_count, checks_done);
    if (err_count == 0 && checks_done > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // Watchdog: the sequence needs well under 200 cycles
  initial begin
    repeat (2000) @(posedge clk);
    err_count++;
    report_and_stop();
  end

  initial begin
    clk = 1'h0;
    rst_n = 1'h0;
    ce = 1'h1;
    cfg_rd = 1'h0;
    cfg_wr = 1'h0;
    cfg_addr = 8'h00;
    cfg_wdata = 32'h00000000;
    err_count = 0;
    checks_done = 0;
    sc_m = 2'h0;
    val_m = 8'h00;
    dp_m = 3'h6;
    lt_m = 3'h6;
    repeat (3) @(negedge clk);
    chk_mw(limit_mw, 18'h00000);
    rst_n = 1'h1;
    // Head dword from byte addresses 70h to 72h, then device caps and a hole
    rd(8'h70, 32'h00720010, 1'h1);
    rd(8'h71, 32'h00720010, 1'h1);
    rd(8'h72, 32'h00720010, 1'h1);
    rd(8'h74, dev_caps(), 1'h1);
    rd(8'h78, 32'h00000000, 1'h0);
    idle();
    // Writes of all ones to mapped and unmapped places are dropped
    cfg_wr = 1'h1;
    cfg_wdata = 32'hFFFFFFFF;
    for (int i = 0; i < 3; i++) begin
      cfg_addr = 8'h70 + 8'(4 * i);
      @(negedge clk);
    end
    cfg_wr = 1'h0;
    rd(8'h70, 32'h00720010, 1'h1);
    rd(8'h74, dev_caps(), 1'h1);
    // Every tolerance code, some below the floors on purpose
    for (int i = 0; i < 8; i++) begin
      root_u.write_gcr(3'(i), 3'(7 - i));
      dp_m = (3'(i) < DF) ? DF : 3'(i);
      lt_m = (3'(7 - i) < LF) ? LF : 3'(7 - i);
      rd(8'h74, dev_caps(), 1'h1);
    end
    idle();
    // Every scale code with its power limit
    for (int i = 0; i < 4; i++) begin
      root_u.send_msg(2'(i), 8'hC9 ^ 8'(i));
      sc_m = 2'(i);
      val_m = 8'hC9 ^ 8'(i);
      rd(8'h74, dev_caps(), 1'h1);
      chk_mw(limit_mw, exp_mw());
    end
    idle();
    // Clock enable low: read and message both ignored
    ce = 1'h0;
    cfg_rd = 1'h1;
    cfg_addr = 8'h74;
    root_u.send_msg(2'h0, 8'h01);
    chk_flag(rd_valid, 1'h0);
    ce = 1'h1;
    rd(8'h74, dev_caps(), 1'h1);
    chk_mw(limit_mw, exp_mw());
    idle();
    // Reset in mid run brings back the defaults
    rst_n = 1'h0;
    @(negedge clk);
    chk_data(rd_data, 32'h00000000);
    chk_mw(limit_mw, 18'h00000);
    rst_n = 1'h1;
    rd(8'h74, 32'h00008D82, 1'h1);
    idle();
    report_and_stop();
  end
endmodule

// >>> test/pcr_root_model.sv
`timescale 1ns/1ps
// ****************************************
// Root complex stand-in
// ****************************************
module pcr_root_model (
  input wire logic clk,
  output logic msg_valid,
  output logic [9:0] msg_payload,
  output logic gcr_wr,
  output logic [31:0] gcr_wdata
);
  // Quiet lines at time zero
  initial begin
    msg_valid = 1'h0;
    msg_payload = 10'h000;
    gcr_wr = 1'h0;
    gcr_wdata = 32'h00000000;
  end

  // Called just after a falling edge; strobe stands one cycle
  // scale and value
  task automatic send_msg(input logic [1:0] sc, input logic [7:0] val);
    msg_valid = 1'h1;
    msg_payload = {sc, val};
    @(negedge clk);
    msg_valid = 1'h0;
    // Stale payload is inverted so a late sample is caught
    msg_payload = ~msg_payload;
  endtask

  // Other control bits set high to show the fields are isolated
  // tolerance codes
  task automatic write_gcr(input logic [2:0] dp, input logic [2:0] lt);
    gcr_wr = 1'h1;
    gcr_wdata = 32'hFFF81FFF | {13'h0000, lt, dp, 13'h0000};
    @(negedge clk);
    gcr_wr = 1'h0;
    gcr_wdata = ~gcr_wdata;
  endtask
endmodule
